//--- hw/sipm_regs.v
// Identification and power management register bank
//
// Behaviour
// - Id high bit 7 reads zero; writes ignored
// - Id high bits 6:4 reserved, writes ignored
// - Fixed 12-bit part number across both bytes
// - Warning flag sticky until acknowledged
// - Flag sets on warning, also after reset
// - Acknowledge clears flag only without warning present
// - Interrupt request while flag and enable set
// - Detect reset only when detect enabled
// - Stop enable keeps detection during stop
// - Detect enable qualifies reset and stop enables
// - Bit 0 drives bandgap buffer enable
// - Write-once bit 5 selects detect range
// - Bit 4 selects warning level within range
// - Recovery flag set after partial power down
// - Writing one to bit 2 clears flag
// - Write-once bit 0 selects stop mode
// - Write-once bits locked until relevant reset

`include "sipm_map.vh"

module sipm_regs (
  // Clock and reset
  input  wire       SYS_CLK_I,
  input  wire       SRST_I,
  // Power-on reset marker, high during the power-on reset only
  input  wire       POR_I,
  // Register port
  input  wire [2:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  // Analog and power sequencer status (asynchronous)
  input  wire       LOW_VOLTAGE_WARNING_I,
  input  wire       LOW_VOLTAGE_DETECT_I,
  input  wire       STOP_MODE_I,
  input  wire       PPD_RECOVERED_I,
  // Controls to analog and power sequencer
  output reg        DETECT_ENABLE_O,
  output reg        DETECT_RESET_REQ_O,
  output reg        BANDGAP_BUFFER_ENABLE_O,
  output reg        DETECT_LEVEL_SELECT_O,
  output reg  [1:0] WARNING_LEVEL_O,
  output reg        PARTIAL_POWERDOWN_SELECT_O,
  // Interrupts
  output reg        WARNING_IRQ_O,
  output reg        IRQ_O
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  reg       ppd_prev_ff;
  reg       det_prev_ff;

  // Two-stage capture of asynchronous status
  always @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {PPD_RECOVERED_I, STOP_MODE_I, LOW_VOLTAGE_DETECT_I, LOW_VOLTAGE_WARNING_I};
      sync2_ff <= sync1_ff;
    end
  end

  wire warn_s = sync2_ff[0];
  wire det_s  = sync2_ff[1];
  wire stop_s = sync2_ff[2];
  wire ppd_s  = sync2_ff[3];

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg       wflag_ff;
  reg       wie_ff;
  reg       dre_ff;
  reg       dse_ff;
  reg       de_ff;
  reg       bandgap_buffer_enable_ff;
  reg       dlv_ff;
  reg       wlv_ff;
  reg       partial_powerdown_flag_ff;
  reg       ppdsel_ff;
  reg       lock1_ff;   // Locks first register's write-once bits
  reg       lock_dlv_ff;
  reg       lock_ppd_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;

  wire wr1 = WR_I && (ADDR_I == `SIPM_OFF_PMCS1);
  wire wr2 = WR_I && (ADDR_I == `SIPM_OFF_PMCS2);
  wire wrs = WR_I && (ADDR_I == `SIPM_OFF_IRQ_STAT);
  wire wrm = WR_I && (ADDR_I == `SIPM_OFF_IRQ_MASK);

  // Detection is active when enabled and not stopped without stop enable
  wire det_active = de_ff && (!stop_s || dse_ff);

  // Events seen by the interrupt status
  wire warn_rise = warn_s && !wflag_ff;
  wire det_evt   = det_active && det_s && !det_prev_ff;
  wire ppd_evt   = ppd_s && !ppd_prev_ff;
  wire [2:0] evt = {ppd_evt, det_evt, warn_rise};

  // ****************************************************************
  // Control and status bits
  // ****************************************************************
  always @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      wflag_ff    <= 1'b0;
      wie_ff      <= 1'b0;
      dre_ff      <= 1'b0;
      dse_ff      <= 1'b1;
      de_ff       <= 1'b1;
      bandgap_buffer_enable_ff     <= 1'b0;
      wlv_ff      <= 1'b0;
      ppdsel_ff   <= 1'b0;
      lock1_ff    <= 1'b0;
      lock_ppd_ff <= 1'b0;
      ppd_prev_ff <= 1'b0;
      det_prev_ff <= 1'b0;
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
    end else begin
      ppd_prev_ff <= ppd_s;
      det_prev_ff <= det_s;
      // Sticky warning: set wins, ack clears only without warning
      if (warn_s)
        wflag_ff <= 1'b1;
      else if (wr1 && WDATA_I[`SIPM_B1_WACK])
        wflag_ff <= 1'b0;
      if (wr1) begin
        wie_ff  <= WDATA_I[`SIPM_B1_WIE];
        dse_ff  <= WDATA_I[`SIPM_B1_DSE];
        bandgap_buffer_enable_ff <= WDATA_I[`SIPM_B1_BANDGAP_BUFFER_ENABLE];
        if (!lock1_ff) begin
          dre_ff   <= WDATA_I[`SIPM_B1_DRE];
          de_ff    <= WDATA_I[`SIPM_B1_DE];
          lock1_ff <= 1'b1;
        end
      end
      if (wr2) begin
        wlv_ff <= WDATA_I[`SIPM_B2_WLV];
        if (!lock_ppd_ff) begin
          ppdsel_ff   <= WDATA_I[`SIPM_B2_PPDSEL];
          lock_ppd_ff <= 1'b1;
        end
      end
      // Status bits: event set wins over write-one clear
      irq_stat_ff <= evt | (irq_stat_ff & ~(wrs ? WDATA_I[2:0] : 3'h0));
      if (wrm)
        irq_mask_ff <= WDATA_I[2:0];
    end
  end

  // ****************************************************************
  // Bits kept across ordinary resets, cleared by power-on reset
  // ****************************************************************
  always @(posedge SYS_CLK_I) begin
    if (POR_I) begin
      dlv_ff      <= 1'b0;
      lock_dlv_ff <= 1'b0;
      partial_powerdown_flag_ff     <= 1'b0;
    end else begin
      if (wr2 && !lock_dlv_ff && !SRST_I) begin
        dlv_ff      <= WDATA_I[`SIPM_B2_DLV];
        lock_dlv_ff <= 1'b1;
      end
      // Recovery flag: set wins over acknowledge
      if (ppd_evt && !SRST_I)
        partial_powerdown_flag_ff <= 1'b1;
      else if (wr2 && WDATA_I[`SIPM_B2_PARTIAL_POWERDOWN_ACK] && !SRST_I)
        partial_powerdown_flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Read multiplexer and registered outputs
  // ****************************************************************
  reg [7:0] nxt_rdata;

  // Part number split into its two byte fields without truncating a wider constant
  wire [11:0] part_id = `SIPM_PART_ID;

  // Read data selection
  always @* begin
    nxt_rdata = 8'h00;
    case (ADDR_I)
      `SIPM_OFF_ID_HIGH: nxt_rdata = {4'h0, part_id[11:8]};
      `SIPM_OFF_ID_LOW:  nxt_rdata = part_id[7:0];
      `SIPM_OFF_PMCS1:   nxt_rdata = {wflag_ff, 1'b0, wie_ff, dre_ff,
                                      dse_ff, de_ff, 1'b0, bandgap_buffer_enable_ff};
      `SIPM_OFF_PMCS2:   nxt_rdata = {2'h0, dlv_ff, wlv_ff, partial_powerdown_flag_ff,
                                      2'h0, ppdsel_ff};
      `SIPM_OFF_IRQ_STAT: nxt_rdata = {5'h00, irq_stat_ff};
      `SIPM_OFF_IRQ_MASK: nxt_rdata = {5'h00, irq_mask_ff};
      default:           nxt_rdata = 8'h00;
    endcase
  end

  // Output flip-flops
  always @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      RDATA_O                    <= 8'h00;
      DETECT_ENABLE_O            <= 1'b0;
      DETECT_RESET_REQ_O         <= 1'b0;
      BANDGAP_BUFFER_ENABLE_O    <= 1'b0;
      DETECT_LEVEL_SELECT_O      <= 1'b0;
      WARNING_LEVEL_O            <= 2'h0;
      PARTIAL_POWERDOWN_SELECT_O <= 1'b0;
      WARNING_IRQ_O              <= 1'b0;
      IRQ_O                      <= 1'b0;
    end else begin
      RDATA_O                    <= RD_I ? nxt_rdata : 8'h00;
      DETECT_ENABLE_O            <= det_active;
      DETECT_RESET_REQ_O         <= det_active && dre_ff && det_s;
      BANDGAP_BUFFER_ENABLE_O    <= bandgap_buffer_enable_ff;
      DETECT_LEVEL_SELECT_O      <= dlv_ff;
      WARNING_LEVEL_O            <= {dlv_ff, wlv_ff};
      PARTIAL_POWERDOWN_SELECT_O <= ppdsel_ff;
      WARNING_IRQ_O              <= wie_ff && wflag_ff;
      IRQ_O                      <= |(irq_stat_ff & irq_mask_ff);
    end
  end

endmodule // sipm_regs

//--- hw/sipm_map.vh
// Register offsets, field positions and part identification of the id and power block
`ifndef SIPM_MAP_VH
`define SIPM_MAP_VH

// ****************************************************************
// Register offsets (byte index on the plain register port)
// ****************************************************************
`define SIPM_ADDR_W          3
`define SIPM_OFF_ID_HIGH     3'h0
`define SIPM_OFF_ID_LOW      3'h1
`define SIPM_OFF_PMCS1       3'h2
`define SIPM_OFF_PMCS2       3'h3
`define SIPM_OFF_IRQ_STAT    3'h4
`define SIPM_OFF_IRQ_MASK    3'h5

// ****************************************************************
// Part identification (value is arbitrary)
// ****************************************************************
`define SIPM_PART_ID         12'h5A3

// ****************************************************************
// First power control register fields
// ****************************************************************
`define SIPM_B1_WFLAG        7
`define SIPM_B1_WACK         6
`define SIPM_B1_WIE          5
`define SIPM_B1_DRE          4
`define SIPM_B1_DSE          3
`define SIPM_B1_DE           2
`define SIPM_B1_BANDGAP_BUFFER_ENABLE         0

// ****************************************************************
// Second power control register fields
// ****************************************************************
`define SIPM_B2_DLV          5
`define SIPM_B2_WLV          4
`define SIPM_B2_PARTIAL_POWERDOWN_FLAG         3
`define SIPM_B2_PARTIAL_POWERDOWN_ACK       2
`define SIPM_B2_PPDSEL       0

// ****************************************************************
// Interrupt status and mask layout
// ****************************************************************
`define SIPM_IRQ_W           3
`define SIPM_IRQ_WARN        0
`define SIPM_IRQ_DETECT      1
`define SIPM_IRQ_PPD         2

`endif

//--- verification/sipm_monitor.sv
// Port checker for the id and power management register bank
`include "sipm_map.vh"
module sipm_monitor (
  // Clock, reset and register port
  input logic       SYS_CLK_I,
  input logic       SRST_I,
  input logic [2:0] ADDR_I,
  input logic       RD_I,
  input logic [7:0] RDATA_O,
  // Controls and interrupt
  input logic       DETECT_ENABLE_O,
  input logic       DETECT_RESET_REQ_O,
  input logic       BANDGAP_BUFFER_ENABLE_O,
  input logic       DETECT_LEVEL_SELECT_O,
  input logic [1:0] WARNING_LEVEL_O,
  input logic       PARTIAL_POWERDOWN_SELECT_O,
  input logic       WARNING_IRQ_O
);
  // ****************************************************************
  // Read answers against part number and control outputs, plus reserved bits and reset request
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SRST_I);
  // Read request, answer in the following cycle
  sequence s_rd(logic [2:0] a);
    RD_I && ADDR_I == a ##1 1'b1;
  endsequence
  property p_idh; s_rd(3'h0) |-> {RDATA_O[7], RDATA_O[3:0]} == {1'b0, 4'h5}; endproperty
  a_idh: assert property (p_idh) else $error("id high wrong");
  property p_idl; s_rd(3'h1) |-> RDATA_O == 8'hA3; endproperty
  a_idl: assert property (p_idl) else $error("id low wrong");
  property p_wirq; s_rd(3'h2) |-> WARNING_IRQ_O == (RDATA_O[7] & RDATA_O[5]); endproperty
  a_wirq: assert property (p_wirq) else $error("warning irq wrong");
  property p_bg; s_rd(3'h2) |-> BANDGAP_BUFFER_ENABLE_O == RDATA_O[0]; endproperty
  a_bg: assert property (p_bg) else $error("bandgap wrong");
  property p_dlv; s_rd(3'h3) |-> DETECT_LEVEL_SELECT_O == RDATA_O[5]; endproperty
  a_dlv: assert property (p_dlv) else $error("detect level wrong");
  property p_wlv; s_rd(3'h3) |-> WARNING_LEVEL_O == RDATA_O[5:4]; endproperty
  a_wlv: assert property (p_wlv) else $error("warning level wrong");
  property p_pps; s_rd(3'h3) |-> PARTIAL_POWERDOWN_SELECT_O == RDATA_O[0]; endproperty
  a_pps: assert property (p_pps) else $error("stop mode wrong");
  property p_drq; DETECT_RESET_REQ_O |-> DETECT_ENABLE_O; endproperty
  a_drq: assert property (p_drq) else $error("reset without detect");
  property p_rs2; s_rd(3'h3) |-> {RDATA_O[7:6], RDATA_O[2:1]} == 4'h0; endproperty
  a_rs2: assert property (p_rs2) else $error("unused bits set");
endmodule // sipm_monitor

bind sipm_regs sipm_monitor sipm_monitor_inst (
  .SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .DETECT_ENABLE_O(DETECT_ENABLE_O),
  .DETECT_RESET_REQ_O(DETECT_RESET_REQ_O), .WARNING_IRQ_O(WARNING_IRQ_O),
  .BANDGAP_BUFFER_ENABLE_O(BANDGAP_BUFFER_ENABLE_O),
  .DETECT_LEVEL_SELECT_O(DETECT_LEVEL_SELECT_O), .WARNING_LEVEL_O(WARNING_LEVEL_O),
  .PARTIAL_POWERDOWN_SELECT_O(PARTIAL_POWERDOWN_SELECT_O));

//--- verification/tb_sipm_regs.sv
// Self-checking bench of the id and power management register bank
`include "sipm_map.vh"
module tb_sipm_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] PID = `SIPM_PART_ID;
  logic       clk, rst, por, wr, rd, warn, det, stp, ppd;
  logic [2:0] addr;
  logic [7:0] wdata, q;
  wire  [7:0] rdata;
  wire        den, drq, bandgap_buffer_enable, dlv, pps, wirq, irq;
  wire  [1:0] wlv;
  int         errors, total_checks, cyc;
  sipm_regs sipm_regs_inst (.SYS_CLK_I(clk), .SRST_I(rst), .POR_I(por), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LOW_VOLTAGE_WARNING_I(warn),
    .LOW_VOLTAGE_DETECT_I(det), .STOP_MODE_I(stp), .PPD_RECOVERED_I(ppd),
    .DETECT_ENABLE_O(den), .DETECT_RESET_REQ_O(drq), .BANDGAP_BUFFER_ENABLE_O(bandgap_buffer_enable),
    .DETECT_LEVEL_SELECT_O(dlv), .WARNING_LEVEL_O(wlv), .PARTIAL_POWERDOWN_SELECT_O(pps),
    .WARNING_IRQ_O(wirq), .IRQ_O(irq));
  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read, answer sampled while it stands, masked compare
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      conclude;
    end
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {rst, por} = 2'b11;
    {wr, rd, warn, det, stp, ppd} = 6'h00;
    addr = 3'h0;
    wdata = 8'h00;
    tick(16);
    {rst, por} <= 2'b00;
    wr_reg(3'h0, 8'hFF);
    wr_reg(3'h1, 8'h00);
    rc(3'h0, {4'h0, PID[11:8]}, 8'h8F);
    rc(3'h1, PID[7:0]);
    rc(3'h2, 8'h0C);
    rc(3'h3, 8'h00);
    rc(3'h6, 8'h00);
    @(posedge clk) warn <= 1'b1;
    tick(6);
    rc(3'h2, 8'h8C);
    rc(3'h4, 8'h01, 8'h01);
    chk(irq, 1'b0);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h2, 8'h7D);
    tick(2);
    rc(3'h2, 8'hBD);
    chk({wirq, bandgap_buffer_enable, irq}, 3'h7);
    @(posedge clk) warn <= 1'b0;
    tick(6);
    rc(3'h2, 8'hBD);
    wr_reg(3'h2, 8'h41);
    tick(2);
    rc(3'h2, 8'h15);
    chk({wirq, bandgap_buffer_enable}, 2'h1);
    wr_reg(3'h4, 8'h07);
    tick(2);
    chk(irq, 1'b0);
    @(posedge clk) det <= 1'b1;
    tick(6);
    chk({den, drq}, 2'h3);
    @(posedge clk) stp <= 1'b1;
    tick(6);
    chk({den, drq}, 2'h0);
    {det, stp} <= 2'b00;
    wr_reg(3'h3, 8'h31);
    tick(2);
    rc(3'h3, 8'h31);
    chk({dlv, wlv, pps}, 4'hF);
    wr_reg(3'h3, 8'h00);
    tick(2);
    rc(3'h3, 8'h21);
    chk(wlv, 2'h2);
    @(posedge clk) ppd <= 1'b1;
    tick(6);
    rc(3'h3, 8'h29);
    @(posedge clk) ppd <= 1'b0;
    wr_reg(3'h3, 8'h25);
    tick(2);
    rc(3'h3, 8'h21);
    {rst, warn} <= 2'b11;
    tick(3);
    rst <= 1'b0;
    tick(6);
    rc(3'h2, 8'h8C);
    wr_reg(3'h3, 8'h01);
    tick(2);
    rc(3'h3, 8'h21);
    conclude;
  end
endmodule // tb_sipm_regs
